// *** rtl/cre_pkg.sv ***
package cre_pkg;
   localparam int PC_W = 21;                      // Program counter width
   localparam int LVL_W = 5;                      // Stack level width
   // Opcode patterns
   localparam logic [15:0] CALL_MASK = 16'hf800;
   localparam logic [15:0] CALL_VAL = 16'hd800;
   localparam logic [15:0] RESET_VAL = 16'h00ff;
   localparam logic [15:0] INTRET_MASK = 16'hfffe;
   localparam logic [15:0] INTRET_VAL = 16'h0010;
   localparam logic [15:0] LITRET_MASK = 16'hff00;
   localparam logic [15:0] LITRET_VAL = 16'h0c00;
   // Register byte offsets
   localparam logic [7:0] ADR_INSTR = 8'h00;
   localparam logic [7:0] ADR_PC = 8'h04;
   localparam logic [7:0] ADR_ACC = 8'h08;
   localparam logic [7:0] ADR_FLAGS = 8'h0c;
   localparam logic [7:0] ADR_BANK = 8'h10;
   localparam logic [7:0] ADR_SACC = 8'h14;
   localparam logic [7:0] ADR_SFLAGS = 8'h18;
   localparam logic [7:0] ADR_SBANK = 8'h1c;
   localparam logic [7:0] ADR_IRQ = 8'h20;
   localparam logic [7:0] ADR_PCHI = 8'h24;
   localparam logic [7:0] ADR_PCUP = 8'h28;
   localparam logic [7:0] ADR_STATE = 8'h2c;
   localparam logic [7:0] ADR_STACK = 8'h30;
   // Field positions
   localparam int IRQ_HIGH_BIT = 7;
   localparam int IRQ_LOW_BIT = 6;
   localparam int IRQ_LVL_BIT = 0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ILL_BIT = 1;
   localparam int STK_LVL_LSB = 24;
   // Reset values
   localparam logic [PC_W-1:0] PC_RST = 21'h000000;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [7:0] LATCH_RST = 8'h00;
   // Quarter phases
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q4 = 2'h3;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_CALL = 3'b001,
      OP_RESET = 3'b010,
      OP_INTRET = 3'b011,
      OP_LITRET = 3'b100
   } cre_op_t;
   typedef enum logic {
      EX_IDLE = 1'b0,
      EX_RUN = 1'b1
   } cre_ex_t;
   typedef struct packed {
      cre_op_t op;                                 // Decoded operation
      logic [10:0] offset;                         // Signed word offset
      logic shadow;                                // Shadow restore select
      logic [7:0] literal;                         // Immediate value
   } cre_dec_t;
endpackage : cre_pkg

// *** rtl/cre_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module cre_decode (
   input wire logic [15:0] instr,                 // Instruction word
   output cre_pkg::cre_dec_t dec                  // Decoded fields
);
   // Pure pattern match, no state
   always_comb begin
      dec.offset = instr[10:0];
      dec.shadow = instr[0];
      dec.literal = instr[7:0];
      if ((instr & cre_pkg::CALL_MASK) == cre_pkg::CALL_VAL) begin
         dec.op = cre_pkg::OP_CALL;
      end else if (instr == cre_pkg::RESET_VAL) begin
         dec.op = cre_pkg::OP_RESET;
      end else if ((instr & cre_pkg::INTRET_MASK) == cre_pkg::INTRET_VAL) begin
         dec.op = cre_pkg::OP_INTRET;
      end else if ((instr & cre_pkg::LITRET_MASK) == cre_pkg::LITRET_VAL) begin
         dec.op = cre_pkg::OP_LITRET;
      end else begin
         dec.op = cre_pkg::OP_NONE;               // Anything else is a nop here
      end
   end
endmodule : cre_decode
`default_nettype wire

// *** rtl/cre_ret_stack.sv ***
`timescale 1ns/10ps
`default_nettype none
module cre_ret_stack #(
   parameter int DEPTH = 31,                      // Entries
   parameter int W = 21                           // Entry width
) (
   input wire logic clk,                          // Clock
   input wire logic rst_n,                        // Async reset, low
   input wire logic clear,                        // Empty the stack
   input wire logic push,                         // Push request
   input wire logic pop,                          // Pop request
   input wire logic [W-1:0] push_data,            // Value to push
   output logic [W-1:0] top,                      // Current top entry
   output logic [cre_pkg::LVL_W-1:0] level        // Entries held
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;               // Entry storage
      logic [cre_pkg::LVL_W-1:0] ptr;             // Next free slot
   } cre_stk_t;
   localparam logic [cre_pkg::LVL_W-1:0] FULL = cre_pkg::LVL_W'(DEPTH);
   cre_stk_t stk_ff;
   cre_stk_t nxt_stk;
   // Full push is dropped and empty pop ignored, so pointer never wraps
   always_comb begin
      nxt_stk = stk_ff;
      if (clear) begin
         nxt_stk.ptr = '0;
      end else if (push && stk_ff.ptr != FULL) begin
         nxt_stk.mem[stk_ff.ptr] = push_data;
         nxt_stk.ptr = stk_ff.ptr + 5'h01;
      end else if (pop && stk_ff.ptr != '0) begin
         nxt_stk.ptr = stk_ff.ptr - 5'h01;
      end
   end
   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stk_ff <= '0;
      end else begin
         stk_ff <= nxt_stk;
      end
   end
   assign top = (stk_ff.ptr == '0) ? '0 : stk_ff.mem[stk_ff.ptr - 5'h01];
   assign level = stk_ff.ptr;
endmodule : cre_ret_stack
`default_nettype wire

// *** rtl/cre_exec.sv ***
`timescale 1ns/10ps
`default_nettype none
module cre_exec #(
   parameter int Q_DIV = 1,                       // Clocks per quarter
   parameter int STK_DEPTH = 31                   // Return stack entries
) (
   input wire logic hclk,                         // Bus clock
   input wire logic hresetn,                      // Async reset, low
   input wire logic hsel,                         // Slave select
   input wire logic [31:0] haddr,                 // Address
   input wire logic [1:0] htrans,                 // Transfer type
   input wire logic hwrite,                       // Write not read
   input wire logic [2:0] hsize,                  // Transfer size
   input wire logic [31:0] hwdata,                // Write data
   input wire logic hready,                       // Bus ready
   output logic hreadyout,                        // Slave ready
   output logic hresp,                            // Response
   output logic [31:0] hrdata,                    // Read data
   output logic refetch,                          // Prefetch discard pulse
   output logic soft_reset                        // Software reset pulse
);
   typedef struct packed {
      cre_pkg::cre_ex_t ex;                       // Execution state
      logic [1:0] q;                              // Quarter phase
      logic cyc;                                  // Second cycle marker
      logic [7:0] div;                            // Quarter divider
      logic [15:0] instr;                         // Instruction in flight
      // Architectural registers
      logic [cre_pkg::PC_W-1:0] program_counter;  // Program counter
      logic [7:0] acc;                            // Working accumulator
      logic [7:0] flags;                          // Status flags
      logic [3:0] bank_select_reg;                // Bank select
      logic [7:0] shadow_accumulator;             // Shadow accumulator
      logic [7:0] shadow_flags;                   // Shadow status
      logic [3:0] shadow_bank_select;             // Shadow bank select
      logic global_irq_enable_high;               // High enable
      logic peripheral_irq_enable_low;            // Low enable
      logic irq_level_low;                        // Servicing low level
      logic [7:0] pc_high_latch;                  // PC high latch
      logic [4:0] pc_upper_latch;                 // PC upper latch
      logic illegal;                              // Unknown opcode seen
      // Bus slave bookkeeping
      logic wr_pend;                              // Write data phase due
      logic [7:0] adr;                            // Captured address
      logic [31:0] rdata;                         // Read data
      logic refetch;                              // Refetch pulse
      logic srst;                                 // Soft reset pulse
   } cre_core_t;

   // Terminal count of the quarter divider
   localparam logic [7:0] Q_LAST = 8'(Q_DIV - 1);

   // Block state apart from the return stack in u_stk lives in one register
   cre_core_t st_ff;
   cre_core_t nxt_st;
   cre_pkg::cre_dec_t dec;
   // Strobes below are combinational; act_q2, act_q4 and the stack controls last one clock, qen stays high when Q_DIV is 1
   logic qen;                                     // Quarter enable
   logic act_q2;                                  // First cycle, Q2 edge
   logic act_q4;                                  // First cycle, Q4 edge
   logic stk_push;                                // Stack push
   logic stk_pop;                                 // Stack pop
   logic stk_clear;                               // Stack clear
   logic [cre_pkg::PC_W-1:0] ret_addr;            // Return address
   logic [cre_pkg::PC_W-1:0] call_target;         // Call target
   logic [cre_pkg::PC_W-1:0] stack_top_entry;     // Stack top
   logic [cre_pkg::LVL_W-1:0] stk_level;          // Stack level
   logic two_cycle;                               // Op needs two cycles

   // Opcode decode of the word in flight
   cre_decode u_dec (
      .instr(st_ff.instr),
      .dec(dec)
   );

   // Hardware return stack
   cre_ret_stack #(
      .DEPTH(STK_DEPTH),
      .W(cre_pkg::PC_W)
   ) u_stk (
      .clk(hclk),
      .rst_n(hresetn),
      .clear(stk_clear),
      .push(stk_push),
      .pop(stk_pop),
      .push_data(ret_addr),
      .top(stack_top_entry),
      .level(stk_level)
   );

   // Phase strobes and stack controls
   always_comb begin
      qen = (st_ff.div == Q_LAST);
      act_q2 = (st_ff.ex == cre_pkg::EX_RUN) && qen && (st_ff.q == cre_pkg::Q2) && !st_ff.cyc;
      act_q4 = (st_ff.ex == cre_pkg::EX_RUN) && qen && (st_ff.q == cre_pkg::Q4) && !st_ff.cyc;
      // Return address doubles as the push value
      ret_addr = st_ff.program_counter + cre_pkg::PC_STEP;
      // Offset counts words, so it is shifted left once
      call_target = ret_addr + {{9{dec.offset[10]}}, dec.offset, 1'b0};
      stk_push = act_q2 && (dec.op == cre_pkg::OP_CALL);
      stk_pop = act_q4 && (dec.op == cre_pkg::OP_INTRET || dec.op == cre_pkg::OP_LITRET);
      stk_clear = act_q2 && (dec.op == cre_pkg::OP_RESET);
      // Reset and unknown words finish in one cycle
      two_cycle = (dec.op != cre_pkg::OP_RESET) && (dec.op != cre_pkg::OP_NONE);
   end

   // Register read view, taken from the next state to avoid stale data
   // The stack word lags a push or pop made in the same cycle
   function automatic logic [31:0] rd_mux(input logic [7:0] a, input cre_core_t s,
                                          input logic [cre_pkg::PC_W-1:0] t,
                                          input logic [cre_pkg::LVL_W-1:0] l);
      logic [31:0] r;
      r = '0;
      case (a)
         cre_pkg::ADR_INSTR: r = {16'h0000, s.instr};
         cre_pkg::ADR_PC: r = {11'h000, s.program_counter};
         cre_pkg::ADR_ACC: r = {24'h000000, s.acc};
         cre_pkg::ADR_FLAGS: r = {24'h000000, s.flags};
         cre_pkg::ADR_BANK: r = {28'h0000000, s.bank_select_reg};
         cre_pkg::ADR_SACC: r = {24'h000000, s.shadow_accumulator};
         cre_pkg::ADR_SFLAGS: r = {24'h000000, s.shadow_flags};
         cre_pkg::ADR_SBANK: r = {28'h0000000, s.shadow_bank_select};
         cre_pkg::ADR_IRQ: begin
            r[cre_pkg::IRQ_HIGH_BIT] = s.global_irq_enable_high;
            r[cre_pkg::IRQ_LOW_BIT] = s.peripheral_irq_enable_low;
            r[cre_pkg::IRQ_LVL_BIT] = s.irq_level_low;
         end
         cre_pkg::ADR_PCHI: r = {24'h000000, s.pc_high_latch};
         cre_pkg::ADR_PCUP: r = {27'h0000000, s.pc_upper_latch};
         cre_pkg::ADR_STATE: begin
            r[cre_pkg::ST_BUSY_BIT] = (s.ex == cre_pkg::EX_RUN);
            r[cre_pkg::ST_ILL_BIT] = s.illegal;
         end
         cre_pkg::ADR_STACK: r = {3'h0, l, 3'h0, t};
         default: r = '0;                         // Unmapped reads as zero
      endcase
      return r;
   endfunction : rd_mux

   // Next-state logic: bus slave first, execution overrides
   always_comb begin
      nxt_st = st_ff;
      nxt_st.refetch = 1'b0;
      nxt_st.srst = 1'b0;
      // Quarter divider runs only while an instruction is in flight
      if (st_ff.ex == cre_pkg::EX_RUN && !qen) begin
         nxt_st.div = st_ff.div + 8'h01;
      end else begin
         nxt_st.div = 8'h00;
      end
      // Write data phase; architectural writes only while idle
      // Dropping busy writes keeps an op from seeing its operands move
      if (st_ff.wr_pend && st_ff.ex == cre_pkg::EX_IDLE) begin
         case (st_ff.adr)
            cre_pkg::ADR_INSTR: begin
               nxt_st.instr = hwdata[15:0];
               nxt_st.ex = cre_pkg::EX_RUN;
               nxt_st.q = 2'h0;
               nxt_st.cyc = 1'b0;
               nxt_st.illegal = 1'b0;
            end
            cre_pkg::ADR_PC: nxt_st.program_counter = hwdata[cre_pkg::PC_W-1:0];
            cre_pkg::ADR_ACC: nxt_st.acc = hwdata[7:0];
            cre_pkg::ADR_FLAGS: nxt_st.flags = hwdata[7:0];
            cre_pkg::ADR_BANK: nxt_st.bank_select_reg = hwdata[3:0];
            cre_pkg::ADR_SACC: nxt_st.shadow_accumulator = hwdata[7:0];
            cre_pkg::ADR_SFLAGS: nxt_st.shadow_flags = hwdata[7:0];
            cre_pkg::ADR_SBANK: nxt_st.shadow_bank_select = hwdata[3:0];
            cre_pkg::ADR_IRQ: begin
               nxt_st.global_irq_enable_high = hwdata[cre_pkg::IRQ_HIGH_BIT];
               nxt_st.peripheral_irq_enable_low = hwdata[cre_pkg::IRQ_LOW_BIT];
               nxt_st.irq_level_low = hwdata[cre_pkg::IRQ_LVL_BIT];
            end
            cre_pkg::ADR_PCHI: nxt_st.pc_high_latch = hwdata[7:0];
            cre_pkg::ADR_PCUP: nxt_st.pc_upper_latch = hwdata[4:0];
            default: begin
            end                                   // Read-only or unmapped
         endcase
      end
      // Q2 of the first cycle
      if (act_q2) begin
         case (dec.op)
            cre_pkg::OP_RESET: begin
               nxt_st.srst = 1'b1;
               nxt_st.program_counter = cre_pkg::PC_RST;
               nxt_st.acc = cre_pkg::ACC_RST;
               nxt_st.flags = cre_pkg::FLAGS_RST;
               nxt_st.bank_select_reg = cre_pkg::BANK_RST;
               nxt_st.shadow_accumulator = cre_pkg::ACC_RST;
               nxt_st.shadow_flags = cre_pkg::FLAGS_RST;
               nxt_st.shadow_bank_select = cre_pkg::BANK_RST;
               nxt_st.global_irq_enable_high = 1'b0;
               nxt_st.peripheral_irq_enable_low = 1'b0;
               nxt_st.irq_level_low = 1'b0;
               nxt_st.pc_high_latch = cre_pkg::LATCH_RST;
               nxt_st.pc_upper_latch = 5'h00;
            end
            default: begin
            end                                   // Push is done by the stack
         endcase
      end
      // Q4 of the first cycle
      if (act_q4) begin
         case (dec.op)
            cre_pkg::OP_CALL: begin
               nxt_st.program_counter = call_target;
            end
            cre_pkg::OP_INTRET: begin
               nxt_st.program_counter = stack_top_entry;
               // The level select decides which enable comes back
               if (st_ff.irq_level_low) begin
                  nxt_st.peripheral_irq_enable_low = 1'b1;
               end else begin
                  nxt_st.global_irq_enable_high = 1'b1;
               end
               if (dec.shadow) begin
                  nxt_st.acc = st_ff.shadow_accumulator;
                  nxt_st.flags = st_ff.shadow_flags;
                  nxt_st.bank_select_reg = st_ff.shadow_bank_select;
               end
            end
            cre_pkg::OP_LITRET: begin
               nxt_st.program_counter = stack_top_entry;
               nxt_st.acc = dec.literal;
            end
            cre_pkg::OP_RESET: begin
            end                                   // Reset already applied in Q2
            default: begin
               // Unknown word: step on and leave a mark for software
               nxt_st.program_counter = ret_addr;  // Plain step past a nop
               nxt_st.illegal = 1'b1;
            end
         endcase
      end
      // Quarter and cycle sequencing
      if (st_ff.ex == cre_pkg::EX_RUN && qen) begin
         nxt_st.q = st_ff.q + 2'h1;
         if (st_ff.q == cre_pkg::Q4) begin
            // Second cycle is a bare nop after the refetch
            if (!st_ff.cyc && two_cycle) begin
               nxt_st.cyc = 1'b1;
               nxt_st.refetch = 1'b1;
            end else begin
               nxt_st.ex = cre_pkg::EX_IDLE;
               nxt_st.cyc = 1'b0;
            end
         end
      end
      // Address phase capture, zero wait states
      // Read view uses the next state so a write just done shows
      nxt_st.wr_pend = 1'b0;
      if (hready && hsel && htrans[1]) begin
         nxt_st.adr = haddr[7:0];
         nxt_st.wr_pend = hwrite;
         if (!hwrite) begin
            nxt_st.rdata = rd_mux(haddr[7:0], nxt_st, stack_top_entry, stk_level);
         end
      end
   end

   // Single state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Zero wait states: the slave never stretches a transfer
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // Read data and pulses come straight from flip-flops
   assign hrdata = st_ff.rdata;
   assign refetch = st_ff.refetch;
   assign soft_reset = st_ff.srst;

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Named steps that the longer checks chain together
   sequence s_call_q4;
      act_q4 && dec.op == cre_pkg::OP_CALL;
   endsequence
   sequence s_pop_q4;
      stk_pop;
   endsequence
   sequence s_iret_q4;
      act_q4 && dec.op == cre_pkg::OP_INTRET;
   endsequence

   // Decode checks
   AST_DEC_CALL: assert property (dec.op == cre_pkg::OP_CALL |-> st_ff.instr[15:11] == 5'h1b)
      else $error("Call decoded from wrong prefix");
   // Call checks
   AST_CALL_PUSH: assert property (stk_push && stk_level != 5'h1f |=> stack_top_entry
         == $past(st_ff.program_counter) + 21'h000002 ##1 act_q4)
      else $error("Call push value or order wrong");
   AST_CALL_PC: assert property (s_call_q4 |=> st_ff.program_counter
         == $past(st_ff.program_counter) + 21'h000002 + {{9{$past(dec.offset[10])}}, $past(dec.offset), 1'b0}
         && $stable(st_ff.flags))
      else $error("Call target or flags wrong");
   AST_CALL_TWO: assert property (s_call_q4 |=> st_ff.refetch ##4 st_ff.ex == cre_pkg::EX_IDLE)
      else $error("Call not two cycles");
   AST_NOP_CYC: assert property (st_ff.cyc |=> $stable(st_ff.program_counter) && $stable(stk_level))
      else $error("Second cycle was not a nop");
   // Reset checks
   AST_SRST: assert property (st_ff.srst |-> st_ff.q == 2'h2 && st_ff.program_counter == 21'h000000
         && st_ff.flags == 8'h00 && stk_level == 5'h00)
      else $error("Software reset incomplete");
   AST_SRST_ALL: assert property (st_ff.srst |-> st_ff.acc == 8'h00 && st_ff.bank_select_reg == 4'h0
         && !st_ff.global_irq_enable_high && !st_ff.peripheral_irq_enable_low)
      else $error("Software reset left live state");
   AST_SRST_ONE: assert property (st_ff.srst |-> ##2 st_ff.ex == cre_pkg::EX_IDLE && !st_ff.refetch)
      else $error("Software reset not one cycle");
   // Return checks
   AST_DEC_RET: assert property (dec.op == cre_pkg::OP_INTRET |-> st_ff.instr[15:1] == 15'h0008)
      else $error("Interrupt return decoded wrongly");
   AST_IRQ_SET: assert property (s_iret_q4 |=>
         (st_ff.global_irq_enable_high || st_ff.peripheral_irq_enable_low)
         && st_ff.program_counter == $past(stack_top_entry))
      else $error("Interrupt return pop or enable missing");
   AST_IRET_TWO: assert property (s_iret_q4 |=> st_ff.refetch ##4 st_ff.ex == cre_pkg::EX_IDLE)
      else $error("Interrupt return not two cycles");
   AST_SHADOW: assert property (s_iret_q4 |=>
         st_ff.acc == ($past(dec.shadow) ? $past(st_ff.shadow_accumulator) : $past(st_ff.acc)))
      else $error("Shadow restore wrong");
   AST_RET_PLAIN: assert property (s_iret_q4 ##0 !dec.shadow |=> $stable(st_ff.flags)
         && $stable(st_ff.bank_select_reg))
      else $error("Plain interrupt return changed flags");
   AST_LATCH: assert property (s_pop_q4 |=> $stable(st_ff.pc_high_latch) && $stable(st_ff.pc_upper_latch))
      else $error("PC latches changed on return");
   AST_RETURN_LITERAL_OP: assert property (act_q4 && dec.op == cre_pkg::OP_LITRET |=> st_ff.acc == $past(dec.literal)
         && $stable(st_ff.flags) ##4 st_ff.ex == cre_pkg::EX_IDLE)
      else $error("Literal return wrong");
   AST_LIT_POP: assert property (act_q4 && dec.op == cre_pkg::OP_LITRET && stk_level != 5'h00 |=> stk_level == $past(stk_level) - 5'h01)
      else $error("Literal return did not pop");
   AST_POP: assert property ((s_pop_q4 and stk_level != 5'h00) |=> stk_level == $past(stk_level) - 5'h01)
      else $error("Pop did not drop one entry");
   AST_REFETCH: assert property (st_ff.refetch |-> st_ff.cyc && st_ff.q == 2'h0)
      else $error("Refetch outside second cycle");
endmodule : cre_exec
`default_nettype wire

// *** tb/cre_fetch_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Fetch side: counts prefetch discards and software resets
module cre_fetch_model (
   input wire logic hclk,        // Clock
   input wire logic hresetn,     // Async reset, low
   input wire logic refetch,     // Prefetch discard pulse
   input wire logic soft_reset,  // Software reset pulse
   output var int refetches,     // Discards seen
   output var int resets         // Resets seen
);
   // Counts only clean highs, so an unknown pulse never counts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         refetches <= 0;
         resets <= 0;
      end else begin
         if (refetch === 1'b1) refetches <= refetches + 1;
         if (soft_reset === 1'b1) resets <= resets + 1;
      end
   end
endmodule : cre_fetch_model
`default_nettype wire

// *** tb/call_return_execute_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module call_return_execute_tb;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, refetch, soft_reset; // Bus and pulses
   logic [1:0] htrans;                 // Transfer type
   logic [31:0] haddr, hwdata, hrdata, r; // Address, data, last read
   int err_total, comparisons, fr, fs, nr, pc, n, k; // Counts and scratch
   // Zero-wait slave drives the bus ready itself
   cre_exec cre_exec_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .refetch(refetch),
      .soft_reset(soft_reset));
   cre_fetch_model cre_fetch_model_i (.hclk(hclk), .hresetn(hresetn), .refetch(refetch),
      .soft_reset(soft_reset), .refetches(fr), .resets(fs));
   // 100 ns clock
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   task end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   task chk(input string s, input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", s, e, g);
      end
   endtask : chk
   // Next edge with ready high, bounded so a hang ends the run
   task wt;
      int i;
      i = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         i++;
         if (i > 50) begin
            err_total++;
            end_sim;
         end
         @(posedge hclk);
      end
   endtask : wt
   // One single AHB transfer: address phase, then data phase
   task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wt;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
      r = hrdata;
   endtask : xf
   task ck(input logic [7:0] a, input logic [31:0] e, input string s);
      xf(1'b0, a, 32'h0);
      chk(s, r, e);
      chk("hresp", 32'(hresp), 32'h0);
   endtask : ck
   // Issue, then poll busy; writes while busy would be dropped
   task issue(input logic [15:0] op);
      int i;
      xf(1'b1, cre_pkg::ADR_INSTR, {16'h0, op});
      for (i = 0; i < 40; i++) begin
         xf(1'b0, cre_pkg::ADR_STATE, 32'h0);
         if (r[0] === 1'b0) return;
      end
      err_total++;
      end_sim;
   endtask : issue
   function logic [31:0] tgt(input int p, input int o);
      return (p + 2 + 2 * o) & 32'h1fffff;
   endfunction : tgt
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      err_total = 0;
      comparisons = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      void'($urandom(31));
      xf(1'b1, cre_pkg::ADR_PCHI, 32'h5a);
      xf(1'b1, cre_pkg::ADR_PCUP, 32'h13);
      xf(1'b1, cre_pkg::ADR_FLAGS, 32'ha5);
      // Three nested calls: both offset extremes, then a random one
      for (int t = 0; t < 3; t++) begin
         n = (t == 0) ? -1024 : (t == 1) ? 1023 : int'($urandom_range(2047)) - 1024;
         pc = 32'h800 + t * 32'h40;
         xf(1'b1, cre_pkg::ADR_PC, pc);
         nr = fr;
         issue(16'hd800 | 16'(n & 32'h7ff));
         ck(cre_pkg::ADR_PC, tgt(pc, n), "pc");
         ck(cre_pkg::ADR_STACK, {3'h0, 5'(t + 1), 3'h0, 21'(pc + 2)}, "stack");
         ck(cre_pkg::ADR_FLAGS, 32'ha5, "flags");
         chk("refetch", fr, nr + 1);
      end
      $display("call test done");
      // Unwind two levels with literal returns
      for (int t = 2; t > 0; t--) begin
         k = $urandom_range(255);
         issue(16'h0c00 | 16'(k));
         ck(cre_pkg::ADR_PC, 32'h802 + t * 32'h40, "pc");
         ck(cre_pkg::ADR_ACC, k, "acc");
         ck(cre_pkg::ADR_STACK, {3'h0, 5'(t), 3'h0, 21'(32'h802 + (t - 1) * 32'h40)}, "stk");
         ck(cre_pkg::ADR_FLAGS, 32'ha5, "flags");
         ck(cre_pkg::ADR_PCHI, 32'h5a, "pchi");
      end
      $display("literal return test done");
      // Interrupt return with shadow restore, high enable
      xf(1'b1, cre_pkg::ADR_SACC, 32'h3c);
      xf(1'b1, cre_pkg::ADR_SFLAGS, 32'h81);
      xf(1'b1, cre_pkg::ADR_SBANK, 32'h9);
      issue(16'h0011);
      ck(cre_pkg::ADR_PC, 32'h802, "pc");
      ck(cre_pkg::ADR_ACC, 32'h3c, "acc");
      ck(cre_pkg::ADR_FLAGS, 32'h81, "flags");
      ck(cre_pkg::ADR_BANK, 32'h9, "bank");
      ck(cre_pkg::ADR_IRQ, 32'h80, "irq");
      // Without restore, low enable selected
      issue(16'hd800);
      xf(1'b1, cre_pkg::ADR_IRQ, 32'h1);
      xf(1'b1, cre_pkg::ADR_SACC, 32'h77);
      issue(16'h0010);
      ck(cre_pkg::ADR_PC, 32'h804, "pc");
      ck(cre_pkg::ADR_ACC, 32'h3c, "acc");
      ck(cre_pkg::ADR_IRQ, 32'h41, "irq");
      ck(cre_pkg::ADR_PCUP, 32'h13, "pcup");
      $display("interrupt return test done");
      // Software reset clears live state and the stack
      issue(16'hd800);
      nr = fs;
      issue(16'h00ff);
      ck(cre_pkg::ADR_ACC, 32'h0, "acc");
      ck(cre_pkg::ADR_PC, 32'h0, "pc");
      ck(cre_pkg::ADR_STACK, 32'h0, "stack");
      chk("soft_reset", fs, nr + 1);
      ck(cre_pkg::ADR_FLAGS, 32'h0, "flags");
      ck(cre_pkg::ADR_IRQ, 32'h0, "irq");
      ck(8'h40, 32'h0, "unmapped");
      // A word that matches no pattern only steps on and flags itself
      issue(16'h1234);
      ck(cre_pkg::ADR_PC, 32'h2, "pc");
      ck(cre_pkg::ADR_STATE, 32'h2, "state");
      $display("reset test done");
      end_sim;
   end
endmodule : call_return_execute_tb
`default_nettype wire
